// File: hw/ecp_port_extended_control.sv
// Extended control, capability report and byte FIFO of the parallel port
// Function
// - Capability bit 7 always reads zero: no hardware compression.
// - Capability bit 6 returns the port interrupt line level.
// - Capability bits 5:3 encode the selected interrupt number.
// - Capability bits 2:0 encode the selected DMA channel.
// - Control bits 7:5 read/write, select the mode; code 101 reserved.
// - Mode 000 resets FIFO, control lines open-drain, data drivers always on.
// - Mode 001 direction tri-states data; data reads return pin levels; push-pull.
// - Mode 010 sends FIFO bytes by standard handshake, forward only, push-pull.
// - Mode 011 forward sends command and data queue; reverse fills data queue.
// - Mode 100 gives EPP only when the configuration option allows it.
// - Mode 110 FIFO read and write by software, never transmitted.
// - Mode 111 maps the two configuration registers at 0x400 and 0x401.
// - Fault disable 0 in ECP mode: falling fault edge pulses interrupt.
// - Clearing fault disable in ECP mode while fault asserted raises an interrupt.
// - DMA enable bit 3 allows DMA only while service bit is zero.
// - Service bit 1 blocks DMA and service interrupts; writing 1 never interrupts.
// - Hardware sets service bit on each service interrupt; software clears it.
// - With DMA enabled, terminal count sets the service bit.
// - DMA off, forward: enough free slots sets the service bit.
// - DMA off, reverse: enough stored bytes sets the service bit.
// - Control bit 1 reads one when FIFO is full.
// - Control bit 0 reads one when FIFO is empty.
// - Clearing service bit with a condition pending interrupts at once.
// - Direction bit 0 means output, 1 input where direction counts.
`timescale 1ns/1ps
`include "ecp_ext_params.svh"
`default_nettype none

module ecp_port_extended_control (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire ecp_ext_pkg::host_req_t host_req_in,
    output logic [7:0] rdata_out,
    input wire logic direction_in,
    input wire logic dma_tc_in,
    input wire logic irq_line_level_in,
    input wire logic epp_option_in,
    input wire logic [3:0] irq_select_in,
    input wire logic [2:0] dma_select_in,
    input wire logic peripheral_error_in,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    output logic rx_ready_out,
    output logic tx_valid_out,
    output ecp_ext_pkg::fifo_entry_t tx_entry_out,
    input wire logic tx_ready_in,
    output logic dma_req_out,
    output logic irq_out,
    output logic data_oe_out,
    output logic ctrl_open_drain_out,
    output logic data_from_pins_out,
    output logic epp_active_out
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] irq_code(input logic [3:0] irq);
        case (irq)
            4'hF: irq_code = 3'h6;
            4'hE: irq_code = 3'h5;
            4'hB: irq_code = 3'h4;
            4'hA: irq_code = 3'h3;
            4'h9: irq_code = 3'h2;
            4'h7: irq_code = 3'h1;
            4'h5: irq_code = 3'h7;
            default: irq_code = 3'h0;
        endcase
    endfunction

    function automatic logic [2:0] dma_code(input logic [2:0] ch);
        case (ch)
            3'h3: dma_code = 3'h3;
            3'h2: dma_code = 3'h2;
            3'h1: dma_code = 3'h1;
            default: dma_code = 3'h0;
        endcase
    endfunction

    function automatic logic fifo_mode(input logic [2:0] m);
        fifo_mode = (m == `MODE_PFIFO) || (m == `MODE_ECP) || (m == `MODE_TEST);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [2:0] mode;
    logic fault_dis;
    logic dma_en;
    logic service;
    ecp_ext_pkg::fifo_entry_t mem [`FIFO_DEPTH];
    logic [`PTR_W-1:0] rd_ptr;
    logic [`PTR_W-1:0] wr_ptr;
    logic [`CNT_W-1:0] count;
    logic [`CNT_W-1:0] next_count;
    logic [`CNT_W-1:0] free_slots;
    logic [7:0] last_byte;
    logic err_s1;
    logic err_s2;
    logic err_prev;
    logic full;
    logic empty;
    logic eff_dir;
    logic fifo_rst;
    logic wr_ecr;
    logic host_push;
    logic rx_push;
    logic push;
    ecp_ext_pkg::fifo_entry_t push_entry;
    logic host_pop;
    logic tx_pop;
    logic pop;
    logic fault_fall;
    logic fault_event;
    logic service_cond;
    logic service_event;
    ecp_ext_pkg::fifo_entry_t buf1;
    logic buf1_v;
    logic buf_ready;
    ecp_ext_pkg::fifo_entry_t next_buf0;
    ecp_ext_pkg::fifo_entry_t next_buf1;
    logic next_buf0_v;
    logic next_buf1_v;

    ////////////////////////////////////////////////////////////////////////
    // Direction is forced out in modes that ignore the bit
    assign eff_dir = (mode == `MODE_SPP || mode == `MODE_PFIFO) ? 1'b0 : direction_in;
    assign fifo_rst = (mode == `MODE_SPP);
    assign full = (count == `FIFO_DEPTH);
    assign empty = (count == {`CNT_W{1'b0}});
    assign free_slots = `FIFO_DEPTH - count;
    assign wr_ecr = host_req_in.wr && (host_req_in.addr == `OFS_ECR);

    // Host writes: FIFO window in PFIFO, test and forward ECP, command queue in forward ECP
    always_comb begin
        host_push = 1'b0;
        push_entry = '{cmd: 1'b0, data: host_req_in.wdata};
        if (host_req_in.wr && !full) begin
            if (host_req_in.addr == `OFS_FIFO) begin
                host_push = (mode == `MODE_PFIFO) || (mode == `MODE_TEST)
                    || (mode == `MODE_ECP && !eff_dir);
            end else if (host_req_in.addr == `OFS_DATA) begin
                host_push = (mode == `MODE_ECP) && !eff_dir;
                push_entry.cmd = 1'b1;
            end
        end
        rx_push = rx_valid_in && rx_ready_out && !full && (mode == `MODE_ECP) && eff_dir;
        if (rx_push) begin
            push_entry = '{cmd: 1'b0, data: rx_data_in};
        end
    end

    assign push = host_push || rx_push;
    assign host_pop = host_req_in.rd && (host_req_in.addr == `OFS_FIFO) && !empty
        && ((mode == `MODE_TEST) || (mode == `MODE_ECP && eff_dir));
    // Test mode never feeds the link
    assign tx_pop = buf_ready && !empty
        && ((mode == `MODE_PFIFO) || (mode == `MODE_ECP && !eff_dir));
    assign pop = host_pop || tx_pop;
    assign next_count = count + {{(`CNT_W-1){1'b0}}, push} - {{(`CNT_W-1){1'b0}}, pop};

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
        end else if (ce_in) begin
            if (fifo_rst) begin
                rd_ptr <= '0;
                wr_ptr <= '0;
                count <= '0;
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + 1'b1;
                end
                count <= next_count;
            end
        end
    end

    // Storage has no reset; pointers and count define its contents
    always_ff @(posedge clk_in) begin
        if (ce_in && push && !fifo_rst) begin
            mem[wr_ptr] <= push_entry;
        end
    end

    // Empty test FIFO re-reads the last byte
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            last_byte <= `BYTE_ZERO;
        end else if (ce_in && host_pop) begin
            last_byte <= mem[rd_ptr].data;
        end
    end

    // Registered from next_count so that ready is already low in the first cycle the FIFO is full
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_ready_out <= 1'b0;
        end else if (ce_in) begin
            rx_ready_out <= !fifo_rst && (next_count < `FIFO_DEPTH) && (mode == `MODE_ECP) && eff_dir;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-entry skid buffer toward the link handshake
    assign buf_ready = !buf1_v;

    always_comb begin
        next_buf0 = tx_entry_out;
        next_buf0_v = tx_valid_out;
        next_buf1 = buf1;
        next_buf1_v = buf1_v;
        if (tx_valid_out && tx_ready_in) begin
            next_buf0 = buf1;
            next_buf0_v = buf1_v;
            next_buf1_v = 1'b0;
        end
        if (tx_pop) begin
            if (!next_buf0_v) begin
                next_buf0 = mem[rd_ptr];
                next_buf0_v = 1'b1;
            end else begin
                next_buf1 = mem[rd_ptr];
                next_buf1_v = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_entry_out <= '0;
            tx_valid_out <= 1'b0;
            buf1 <= '0;
            buf1_v <= 1'b0;
        end else if (ce_in) begin
            tx_entry_out <= next_buf0;
            buf1 <= next_buf1;
            tx_valid_out <= next_buf0_v && !fifo_rst;
            buf1_v <= next_buf1_v && !fifo_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault pin is asynchronous to clk_in
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            err_s1 <= 1'b1;
            err_s2 <= 1'b1;
            err_prev <= 1'b1;
        end else if (ce_in) begin
            err_s1 <= peripheral_error_in;
            err_s2 <= err_s1;
            err_prev <= err_s2;
        end
    end

    assign fault_fall = err_prev && !err_s2;
    // A 1-to-0 write of the disable bit catches a fault already low
    assign fault_event = (mode == `MODE_ECP)
        && ((!fault_dis && fault_fall)
        || (wr_ecr && fault_dis && !host_req_in.wdata[`ECR_FAULT_DIS] && !err_s2));

    ////////////////////////////////////////////////////////////////////////
    // Level conditions re-fire as soon as the service bit is cleared
    always_comb begin
        if (dma_en) begin
            service_cond = dma_tc_in;
        end else if (!eff_dir) begin
            service_cond = free_slots >= `TX_FREE_LEVEL;
        end else begin
            service_cond = count >= `RX_FILL_LEVEL;
        end
    end

    assign service_event = !service && fifo_mode(mode) && service_cond
        && !(wr_ecr && host_req_in.wdata[`ECR_SERVICE]);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            service <= `ECR_RST_SERVICE;
        end else if (ce_in) begin
            if (service_event) begin
                service <= 1'b1;
            end else if (wr_ecr) begin
                service <= host_req_in.wdata[`ECR_SERVICE];
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode <= `ECR_RST_MODE;
            fault_dis <= `ECR_RST_FAULT_DIS;
            dma_en <= `ECR_RST_DMA_EN;
        end else if (ce_in && wr_ecr) begin
            mode <= host_req_in.wdata[`ECR_MODE_HI:`ECR_MODE_LO];
            fault_dis <= host_req_in.wdata[`ECR_FAULT_DIS];
            dma_en <= host_req_in.wdata[`ECR_DMA_EN];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_out <= 1'b0;
        end else if (ce_in) begin
            irq_out <= fault_event || service_event;
        end
    end

    // DMA asks only where a byte can move
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dma_req_out <= 1'b0;
        end else if (ce_in) begin
            dma_req_out <= dma_en && !service && fifo_mode(mode)
                && (eff_dir ? !(next_count == '0) : (next_count < `FIFO_DEPTH));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_oe_out <= 1'b1;
            ctrl_open_drain_out <= 1'b1;
            data_from_pins_out <= 1'b0;
            epp_active_out <= 1'b0;
        end else if (ce_in) begin
            data_oe_out <= !eff_dir;
            ctrl_open_drain_out <= (mode == `MODE_SPP);
            data_from_pins_out <= (mode == `MODE_PS2);
            epp_active_out <= (mode == `MODE_EPP) && epp_option_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= `BYTE_ZERO;
        end else if (ce_in && host_req_in.rd) begin
            case (host_req_in.addr)
                `OFS_FIFO: begin
                    if (mode == `MODE_CFG) begin
                        rdata_out <= `WIDTH_INFO_VAL;
                    end else if (host_pop) begin
                        rdata_out <= mem[rd_ptr].data;
                    end else begin
                        rdata_out <= last_byte;
                    end
                end
                `OFS_CAP: begin
                    if (mode == `MODE_CFG) begin
                        rdata_out <= {`CAP_COMPRESS, irq_line_level_in,
                            irq_code(irq_select_in), dma_code(dma_select_in)};
                    end else begin
                        rdata_out <= `BYTE_ZERO;
                    end
                end
                `OFS_ECR: begin
                    rdata_out <= {mode, fault_dis, dma_en, service, full, empty};
                end
                default: begin
                    rdata_out <= `BYTE_ZERO;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_fault_armed;
        ce_in && mode == `MODE_ECP && fault_dis && !err_s2;
    endsequence

    sequence s_fault_release;
        wr_ecr && !host_req_in.wdata[`ECR_FAULT_DIS];
    endsequence

    AST_FAULT_REENABLE: assert property ((s_fault_armed and s_fault_release) |=> irq_out)
        else $error("fault re-enable lost its interrupt");

    AST_FAULT_DISABLED: assert property (ce_in && fault_dis && !wr_ecr |=> !irq_out || $past(service_event))
        else $error("interrupt while fault disabled");

    AST_FAULT_EDGE: assert property (ce_in && mode == `MODE_ECP && !fault_dis && fault_fall |=> irq_out)
        else $error("fault edge missed");

    AST_SERVICE_SET: assert property (ce_in && service_event |=> service && irq_out)
        else $error("service bit not set by event");

    AST_WRITE1_QUIET: assert property (ce_in && wr_ecr && host_req_in.wdata[`ECR_SERVICE] && !fault_event
        |=> !irq_out)
        else $error("writing service bit caused interrupt");

    AST_NO_DMA_SERVICE: assert property (ce_in && service |=> !dma_req_out)
        else $error("dma request while service set");

    AST_RX_FILL: assert property (ce_in && !service && !dma_en && fifo_mode(mode) && eff_dir
        && count >= `RX_FILL_LEVEL |=> service)
        else $error("read threshold did not set service");

    // Only a clear that keeps the FIFO mode and leaves DMA off must re-fire
    AST_CLEAR_REFIRE: assert property (ce_in && service && wr_ecr && !host_req_in.wdata[`ECR_SERVICE]
        && host_req_in.wdata[`ECR_MODE_HI:`ECR_MODE_LO] == mode && !host_req_in.wdata[`ECR_DMA_EN]
        && fifo_mode(mode) && !eff_dir && free_slots >= `TX_FREE_LEVEL
        |=> ce_in [*1] ##0 service_event)
        else $error("pending condition not raised after clear");

    AST_FULL_REFUSE: assert property (ce_in && full && !pop && !fifo_rst |=> full)
        else $error("full FIFO accepted a byte");

    AST_TEST_NO_TX: assert property (ce_in && mode == `MODE_TEST |-> !tx_pop)
        else $error("test mode fed the link");

    AST_SPP_RESET: assert property (ce_in && fifo_rst |=> empty ##0 !tx_valid_out)
        else $error("FIFO not held in reset");

endmodule // ecp_port_extended_control
`default_nettype wire

// File: shared/ecp_ext_params.svh
// Offsets, field positions, reset values and sizes of the extended control block
`ifndef ECP_EXT_PARAMS_SVH
`define ECP_EXT_PARAMS_SVH

`define ADDR_W 11
`define OFS_DATA 11'h000
`define OFS_FIFO 11'h400
`define OFS_CAP 11'h401
`define OFS_ECR 11'h402

`define MODE_SPP 3'h0
`define MODE_PS2 3'h1
`define MODE_PFIFO 3'h2
`define MODE_ECP 3'h3
`define MODE_EPP 3'h4
`define MODE_RSVD 3'h5
`define MODE_TEST 3'h6
`define MODE_CFG 3'h7

`define ECR_MODE_HI 7
`define ECR_MODE_LO 5
`define ECR_FAULT_DIS 4
`define ECR_DMA_EN 3
`define ECR_SERVICE 2
`define ECR_FULL 1
`define ECR_EMPTY 0

`define ECR_RST_MODE 3'h0
`define ECR_RST_FAULT_DIS 1'h0
`define ECR_RST_DMA_EN 1'h0
`define ECR_RST_SERVICE 1'h1

`define CAP_COMPRESS 1'h0
`define WIDTH_INFO_VAL 8'h10
`define BYTE_ZERO 8'h00

`define PTR_W 4
`define CNT_W 5
`define FIFO_DEPTH 5'h10
`define TX_FREE_LEVEL 5'h08
`define RX_FILL_LEVEL 5'h08

`endif

// File: shared/ecp_ext_pkg.sv
// Types shared by the extended control block
`default_nettype none
package ecp_ext_pkg;
    typedef struct packed {
        logic [10:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic cmd;
        logic [7:0] data;
    } fifo_entry_t;
endpackage
`default_nettype wire

// File: sim/ecp_link_partner.sv
// Model of the handshake logic on the far side of the byte queue
`timescale 1ns/1ps
`default_nettype none

module ecp_link_partner (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic slow_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic rx_go_in,
    input wire logic rx_ready_in,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out
);
    logic [7:0] next_byte;

    ////////////////////////////////////////////////////////////////
    // Slow mode stalls every other cycle; offered bytes stay until taken
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_ready_out <= 1'b0;
            rx_valid_out <= 1'b0;
            next_byte <= 8'hA0;
        end else begin
            tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
            if (rx_valid_out && rx_ready_in)
                next_byte <= next_byte + 8'h01;
            if (!rx_valid_out || rx_ready_in)
                rx_valid_out <= rx_go_in;
        end
    end

    // Idle lines show junk, never the last byte
    assign rx_data_out = rx_valid_out ? next_byte : ~next_byte;
endmodule // ecp_link_partner
`default_nettype wire

// File: sim/ecp_port_extended_control_bench.sv
// Self-checking bench for the extended control block
`timescale 1ns/1ps
`include "ecp_ext_params.svh"
`default_nettype none

module ecp_port_extended_control_bench;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    ecp_ext_pkg::host_req_t req = '0;
    logic dir = 1'b0, tc = 1'b0, lvl = 1'b0, epp_opt = 1'b0, fault_n = 1'b1, slow = 1'b1, rx_go = 1'b0;
    logic [3:0] irq_sel = 4'h0;
    logic [2:0] dma_sel = 3'h0;
    logic ce = 1'b1;
    logic [7:0] rdata, rx_data;
    logic rx_ready, rx_valid, tx_valid, tx_ready, dma_req, irq, data_oe, ctrl_od, pins, epp;
    ecp_ext_pkg::fifo_entry_t tx_entry;
    ecp_ext_pkg::fifo_entry_t tx_log[$];
    int n_errors = 0, check_count = 0, irq_count = 0, cycles = 0;
    wire logic [3:0] drv = {data_oe, ctrl_od, pins, epp};
    logic [3:0] irq_tab [8] = '{4'hF, 4'hE, 4'hB, 4'hA, 4'h9, 4'h7, 4'h5, 4'h3};
    logic [2:0] enc_tab [8] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h7, 3'h0};

    ecp_port_extended_control DUT (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce),
        .host_req_in(req), .rdata_out(rdata), .direction_in(dir), .dma_tc_in(tc),
        .irq_line_level_in(lvl), .epp_option_in(epp_opt), .irq_select_in(irq_sel),
        .dma_select_in(dma_sel), .peripheral_error_in(fault_n), .rx_valid_in(rx_valid),
        .rx_data_in(rx_data), .rx_ready_out(rx_ready), .tx_valid_out(tx_valid),
        .tx_entry_out(tx_entry), .tx_ready_in(tx_ready), .dma_req_out(dma_req), .irq_out(irq),
        .data_oe_out(data_oe), .ctrl_open_drain_out(ctrl_od), .data_from_pins_out(pins),
        .epp_active_out(epp));

    ecp_link_partner partner (.clk_in(clk_in), .resetn_in(resetn_in), .slow_in(slow),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_go_in(rx_go),
        .rx_ready_in(rx_ready), .rx_valid_out(rx_valid), .rx_data_out(rx_data));

    always #50 clk_in = ~clk_in;

    ////////////////////////////////////////////////////////////////
    // Watchers and the hang limit
    always @(posedge clk_in) begin
        cycles++;
        if (irq === 1'b1) irq_count++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) tx_log.push_back(tx_entry);
        if (cycles == 30000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Host register cycles, entered and left just after an edge
    task automatic bus(input logic [10:0] a, input logic w, input logic [7:0] d);
        req.addr = a;
        req.wr = w;
        req.rd = !w;
        req.wdata = d;
        @(posedge clk_in);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b0;
        // Idle edge: a strobe is never dropped and raised in one step, and outputs settle
        @(posedge clk_in);
        #1;
    endtask

    task automatic rd_chk(input logic [10:0] a, input logic [8:0] exp);
        bus(a, 1'b0, 8'h00);
        chk({1'b0, rdata}, exp);
    endtask

    task automatic wecr(input logic [7:0] d);
        bus(`OFS_ECR, 1'b1, d);
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        chk({5'h00, drv}, 9'h00C);
        rd_chk(`OFS_ECR, 8'h05);
        // Clock enable low must freeze the control register
        ce = 1'b0;
        wecr(8'h24);
        ce = 1'b1;
        rd_chk(`OFS_ECR, 8'h05);
    endtask

    task automatic t_cap();
        wecr(8'h24);
        rd_chk(`OFS_CAP, 8'h00);
        wecr(8'hE4);
        rd_chk(`OFS_FIFO, 8'h10);
        for (int i = 0; i < 8; i++) begin
            irq_sel = irq_tab[i];
            dma_sel = i[2:0];
            lvl = i[0];
            pause(2);
            rd_chk(`OFS_CAP, {1'b0, 1'b0, i[0], enc_tab[i], (i < 4) ? i[2:0] : 3'h0});
        end
        wecr(8'h24);
    endtask

    task automatic t_modes();
        dir = 1'b1;
        pause(2);
        chk({5'h00, drv}, 9'h002);
        dir = 1'b0;
        wecr(8'h84);
        pause(2);
        chk({5'h00, drv}, 9'h008);
        epp_opt = 1'b1;
        pause(2);
        chk({5'h00, drv}, 9'h009);
        epp_opt = 1'b0;
        wecr(8'h24);
        wecr(8'hA4);
        rd_chk(`OFS_ECR, 8'hA5);
        wecr(8'h24);
        wecr(8'h04);
        dir = 1'b1;
        pause(2);
        chk({5'h00, drv}, 9'h00C);
        dir = 1'b0;
        wecr(8'h24);
    endtask

    task automatic t_test_fifo();
        int n0 = irq_count;
        int t0 = tx_log.size();
        wecr(8'hC4);
        wecr(8'hC0);
        pause(3);
        chk(irq_count[8:0], n0[8:0] + 9'h001);
        rd_chk(`OFS_ECR, 8'hC5);
        for (int i = 0; i < 17; i++) bus(`OFS_FIFO, 1'b1, 8'h10 + i[7:0]);
        rd_chk(`OFS_ECR, 8'hC6);
        for (int i = 0; i < 16; i++) rd_chk(`OFS_FIFO, 8'h10 + i[7:0]);
        rd_chk(`OFS_FIFO, 8'h1F);
        rd_chk(`OFS_ECR, 8'hC5);
        chk(tx_log.size(), t0[8:0]);
        wecr(8'h24);
    endtask

    task automatic t_fwd();
        int t0 = tx_log.size();
        wecr(8'h64);
        chk({5'h00, drv}, 9'h008);
        bus(`OFS_DATA, 1'b1, 8'h81);
        bus(`OFS_FIFO, 1'b1, 8'h44);
        for (int i = 0; i < 40 && tx_log.size() < t0 + 2; i++) @(posedge clk_in);
        #1;
        chk(tx_log.size(), t0[8:0] + 9'h002);
        chk(tx_log[t0], 9'h181);
        chk(tx_log[t0 + 1], 9'h044);
        wecr(8'h24);
    endtask

    task automatic t_rev();
        int n0 = irq_count;
        dir = 1'b1;
        wecr(8'h64);
        rx_go = 1'b1;
        pause(40);
        chk({5'h00, drv}, 9'h000);
        rd_chk(`OFS_ECR, 8'h66);
        wecr(8'h60);
        pause(3);
        chk(irq_count[8:0], n0[8:0] + 9'h001);
        rd_chk(`OFS_ECR, 8'h66);
        rx_go = 1'b0;
        for (int i = 0; i < 17; i++) rd_chk(`OFS_FIFO, 8'hA0 + i[7:0]);
        rd_chk(`OFS_ECR, 8'h65);
        wecr(8'h24);
        dir = 1'b0;
    endtask

    task automatic t_fault();
        int n0 = irq_count;
        wecr(8'h64);
        fault_n = 1'b0;
        pause(8);
        chk(irq_count[8:0], n0[8:0] + 9'h001);
        fault_n = 1'b1;
        wecr(8'h74);
        pause(4);
        fault_n = 1'b0;
        pause(8);
        chk(irq_count[8:0], n0[8:0] + 9'h001);
        wecr(8'h64);
        pause(4);
        chk(irq_count[8:0], n0[8:0] + 9'h002);
        fault_n = 1'b1;
        wecr(8'h24);
    endtask

    task automatic t_dma();
        int n0 = irq_count;
        wecr(8'h48);
        pause(3);
        chk({8'h00, dma_req}, 9'h001);
        tc = 1'b1;
        pause(1);
        tc = 1'b0;
        pause(3);
        chk(irq_count[8:0], n0[8:0] + 9'h001);
        chk({8'h00, dma_req}, 9'h000);
        rd_chk(`OFS_ECR, 8'h4D);
        wecr(8'h48);
        pause(3);
        chk({8'h00, dma_req}, 9'h001);
        wecr(8'h4C);
        pause(3);
        chk({8'h00, dma_req}, 9'h000);
        chk(irq_count[8:0], n0[8:0] + 9'h001);
        dir = 1'b1;
        wecr(8'h40);
        pause(3);
        chk(irq_count[8:0], n0[8:0] + 9'h002);
        chk({5'h00, drv}, 9'h008);
        dir = 1'b0;
        wecr(8'h24);
    endtask

    initial begin
        pause(8);
        resetn_in = 1'b1;
        pause(1);
        t_reset();
        t_cap();
        t_modes();
        t_test_fifo();
        t_fwd();
        t_rev();
        t_fault();
        t_dma();
        finish_test();
    end
endmodule // ecp_port_extended_control_bench
`default_nettype wire
